// ---- common/aif_pkg.sv ----
`default_nettype none
package aif_pkg;
   localparam int NUM_LINES = 4;
   localparam int RESULT_W = 16;
   localparam int TRIM_W = 8;
   localparam int DIV_W = 4;
   localparam logic [TRIM_W-1:0] TRIM_12_SE = 8'h10;
   localparam logic [TRIM_W-1:0] TRIM_12_DIFF = 8'h20;
   localparam logic [TRIM_W-1:0] TRIM_16_SE = 8'h30;
   localparam logic [TRIM_W-1:0] TRIM_16_DIFF = 8'h40;
   localparam logic [DIV_W-1:0] STALE_DIV_LIMIT = 4'h2;
   localparam int CLK_PERIOD_NS = 10;
   localparam int READ_MIN_DELAY_CYC = 3;
   localparam int DUMMY_XFER_CYC = 2;
   typedef enum logic [2:0] {
      AIF_IDLE = 3'b000,
      AIF_DUMMY = 3'b001,
      AIF_READ = 3'b010,
      AIF_CLEAR = 3'b011,
      AIF_CHECK = 3'b100,
      AIF_RECLEAR = 3'b101
   } aif_host_state_t;
endpackage
`default_nettype wire

// ---- common/aif_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface aif_link_if #(
   parameter int N = aif_pkg::NUM_LINES,
   parameter int W = aif_pkg::RESULT_W
);
   logic [N-1:0] conversion_irq;
   logic [N-1:0] conversion_irq_flag;
   logic [N-1:0] irq_overflow_status;
   logic [N-1:0] irq_flag_clear;
   logic [N-1:0] irq_overflow_clear;
   logic [N-1:0] continue_to_interrupt;
   logic res_16bit;
   logic diff_mode;
   logic rd_req;
   logic [$clog2(N)-1:0] rd_line;
   logic [W-1:0] rd_data;
   logic rd_valid;
   modport dev (
      output conversion_irq, conversion_irq_flag, irq_overflow_status, rd_data, rd_valid,
      input irq_flag_clear, irq_overflow_clear, continue_to_interrupt, res_16bit, diff_mode, rd_req, rd_line
   );
   modport host (
      input conversion_irq, conversion_irq_flag, irq_overflow_status, rd_data, rd_valid,
      output irq_flag_clear, irq_overflow_clear, continue_to_interrupt, res_16bit, diff_mode, rd_req, rd_line
   );
endinterface
`default_nettype wire

// ---- hdl/aif_device.sv ----
`timescale 1ns/1ps
`default_nettype none
module aif_device #(
   parameter int N = aif_pkg::NUM_LINES,
   parameter int W = aif_pkg::RESULT_W
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   aif_link_if.dev link,
   input wire logic [N-1:0] conv_done_i,
   input wire logic [W-1:0] conv_data_i,
   input wire logic late_irq_mode_i,
   input wire logic [aif_pkg::DIV_W-1:0] clk_div_i,
   output logic [aif_pkg::TRIM_W-1:0] offset_trim_o,
   output logic stale_risk_o
);

   // ****************************************
   // Interrupt flag, pulse and overflow per line.
   // ****************************************
   logic [N-1:0] irq;
   logic [N-1:0] flag;
   logic [N-1:0] ovf;
   logic [W-1:0] result [N];

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++) begin : g_line
         always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               irq[gi] <= 1'b0;
            end else if (conv_done_i[gi]) begin
               if (link.continue_to_interrupt[gi]) begin
                  irq[gi] <= 1'b1;
               end else begin
                  irq[gi] <= ~flag[gi];
               end
            end else begin
               irq[gi] <= 1'b0;
            end
         end

         always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               flag[gi] <= 1'b0;
            end else if (conv_done_i[gi]) begin
               flag[gi] <= 1'b1;
            end else if (link.irq_flag_clear[gi]) begin
               flag[gi] <= 1'b0;
            end
         end

         always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               ovf[gi] <= 1'b0;
            end else if (conv_done_i[gi] && flag[gi]) begin
               ovf[gi] <= 1'b1;
            end else if (link.irq_overflow_clear[gi]) begin
               ovf[gi] <= 1'b0;
            end
         end

         always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
               result[gi] <= '0;
            end else if (conv_done_i[gi]) begin
               result[gi] <= conv_data_i;
            end
         end
      end
   endgenerate

   assign link.conversion_irq = irq;
   assign link.conversion_irq_flag = flag;
   assign link.irq_overflow_status = ovf;

   // ****************************************
   // Result read port.
   // ****************************************
   logic [W-1:0] rd_data;
   logic rd_valid;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= link.rd_req;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_data <= '0;
      end else if (link.rd_req) begin
         rd_data <= result[link.rd_line];
      end
   end

   assign link.rd_data = rd_data;
   assign link.rd_valid = rd_valid;

   // ****************************************
   // Offset trim selection.
   // ****************************************
   logic [aif_pkg::TRIM_W-1:0] next_trim;

   always_comb begin
      unique case ({link.res_16bit, link.diff_mode})
         2'b00: next_trim = aif_pkg::TRIM_12_SE;
         2'b01: next_trim = aif_pkg::TRIM_12_DIFF;
         2'b10: next_trim = aif_pkg::TRIM_16_SE;
         2'b11: next_trim = aif_pkg::TRIM_16_DIFF;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         offset_trim_o <= aif_pkg::TRIM_12_SE;
      end else begin
         offset_trim_o <= next_trim;
      end
   end

   // ****************************************
   // Stale-read risk indication.
   // ****************************************
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stale_risk_o <= 1'b0;
      end else begin
         stale_risk_o <= late_irq_mode_i && !link.res_16bit && (clk_div_i > aif_pkg::STALE_DIV_LIMIT);
      end
   end

endmodule // aif_device
`default_nettype wire

// ---- hdl/aif_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module aif_host #(
   parameter int N = aif_pkg::NUM_LINES,
   parameter int W = aif_pkg::RESULT_W,
   parameter int DUMMY_CYC = aif_pkg::DUMMY_XFER_CYC
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   aif_link_if.host link,
   input wire logic [N-1:0] cont_cfg_i,
   input wire logic res_16bit_cfg_i,
   input wire logic diff_mode_cfg_i,
   input wire logic ovf_autoclear_i,
   output logic [W-1:0] result_o,
   output logic [$clog2(N)-1:0] result_line_o,
   output logic result_valid_o,
   output logic lost_o
);
   localparam int LW = $clog2(N);
   localparam int CW = 4;
   localparam logic [CW-1:0] WAIT_CYC = CW'(aif_pkg::READ_MIN_DELAY_CYC + DUMMY_CYC);

   // ****************************************
   // Configuration towards the device.
   // ****************************************
   logic [N-1:0] cont;
   logic res16;
   logic diff;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cont <= '0;
         res16 <= 1'b0;
         diff <= 1'b0;
      end else begin
         cont <= cont_cfg_i;
         res16 <= res_16bit_cfg_i;
         diff <= diff_mode_cfg_i;
      end
   end

   // ****************************************
   // Service sequence.
   // ****************************************
   aif_pkg::aif_host_state_t state;
   logic [LW-1:0] line;
   logic [CW-1:0] cnt;
   logic [N-1:0] flag_clr;
   logic [N-1:0] ovf_clr;
   logic rd_req;
   logic [LW-1:0] pick;
   logic found;

   always_comb begin
      pick = '0;
      found = 1'b0;
      for (int i = N - 1; i >= 0; i--) begin
         if (link.conversion_irq_flag[i]) begin
            pick = LW'(i);
            found = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state <= aif_pkg::AIF_IDLE;
         line <= '0;
         cnt <= '0;
      end else begin
         unique case (state)
            aif_pkg::AIF_IDLE: begin
               if (found) begin
                  line <= pick;
                  cnt <= WAIT_CYC - 4'h1;
                  state <= aif_pkg::AIF_DUMMY;
               end
            end
            aif_pkg::AIF_DUMMY: begin
               if (cnt == '0) begin
                  state <= aif_pkg::AIF_READ;
               end else begin
                  cnt <= cnt - 4'h1;
               end
            end
            aif_pkg::AIF_READ: begin
               if (link.rd_valid) begin
                  state <= aif_pkg::AIF_CLEAR;
               end
            end
            aif_pkg::AIF_CLEAR: state <= aif_pkg::AIF_CHECK;
            aif_pkg::AIF_CHECK: begin
               if (link.irq_overflow_status[line]) begin
                  state <= aif_pkg::AIF_RECLEAR;
               end else begin
                  state <= aif_pkg::AIF_IDLE;
               end
            end
            aif_pkg::AIF_RECLEAR: state <= aif_pkg::AIF_IDLE;
            default: state <= aif_pkg::AIF_IDLE;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_req <= 1'b0;
         flag_clr <= '0;
         ovf_clr <= '0;
      end else begin
         rd_req <= (state == aif_pkg::AIF_DUMMY) && (cnt == '0);
         flag_clr <= '0;
         ovf_clr <= '0;
         if ((state == aif_pkg::AIF_READ && link.rd_valid) || state == aif_pkg::AIF_CHECK) begin
            flag_clr[line] <= (state != aif_pkg::AIF_CHECK) || link.irq_overflow_status[line];
            ovf_clr[line] <= (state == aif_pkg::AIF_CHECK) && ovf_autoclear_i;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_o <= '0;
         result_line_o <= '0;
         result_valid_o <= 1'b0;
         lost_o <= 1'b0;
      end else begin
         result_valid_o <= (state == aif_pkg::AIF_READ) && link.rd_valid;
         lost_o <= (state == aif_pkg::AIF_CHECK) && link.irq_overflow_status[line];
         if (state == aif_pkg::AIF_READ && link.rd_valid) begin
            result_o <= link.rd_data;
            result_line_o <= line;
         end
      end
   end

   assign link.continue_to_interrupt = cont;
   assign link.res_16bit = res16;
   assign link.diff_mode = diff;
   assign link.rd_req = rd_req;
   assign link.rd_line = line;
   assign link.irq_flag_clear = flag_clr;
   assign link.irq_overflow_clear = ovf_clr;

endmodule // aif_host
`default_nettype wire

// ---- bench/aif_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****
// Link checker.
// ****
module aif_sva #(
   parameter int N = 4
) (
   input wire logic ref_clk_i,
   input wire logic rst_b_i,
   input wire logic [N-1:0] conversion_irq,
   input wire logic [N-1:0] conversion_irq_flag,
   input wire logic [N-1:0] irq_overflow_status,
   input wire logic [N-1:0] irq_flag_clear,
   input wire logic [N-1:0] irq_overflow_clear,
   input wire logic [N-1:0] continue_to_interrupt,
   input wire logic rd_req,
   input wire logic rd_valid
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_rd_req;
      rd_req;
   endsequence
   sequence s_rd_ans;
      rd_valid;
   endsequence
   property p_one_shot;
      (conversion_irq & $past(conversion_irq_flag & ~continue_to_interrupt)) == '0;
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("irq on one-shot line with flag set");
   property p_ovf_cause;
      (irq_overflow_status & ~$past(irq_overflow_status) & ~$past(conversion_irq_flag)) == '0;
   endproperty
   a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without prior flag");
   property p_flag_hold;
      ($past(conversion_irq_flag) & ~conversion_irq_flag & ~$past(irq_flag_clear)) == '0;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag fell without clear");
   property p_ovf_hold;
      ($past(irq_overflow_status) & ~irq_overflow_status & ~$past(irq_overflow_clear)) == '0;
   endproperty
   a_ovf_hold: assert property (p_ovf_hold) else $error("overflow fell without clear");
   property p_flag_clear;
      ($past(irq_flag_clear & ~irq_overflow_status) & conversion_irq_flag & ~conversion_irq
         & ~irq_overflow_status) == '0;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
   property p_ovf_clear;
      ($past(irq_overflow_clear & ~conversion_irq_flag) & irq_overflow_status) == '0;
   endproperty
   a_ovf_clear: assert property (p_ovf_clear) else $error("overflow not cleared");
   property p_irq_flag;
      (conversion_irq & ~conversion_irq_flag) == '0;
   endproperty
   a_irq_flag: assert property (p_irq_flag) else $error("irq without flag");
   property p_ovf_flag;
      (irq_overflow_status & ~$past(irq_overflow_status) & ~conversion_irq_flag) == '0;
   endproperty
   a_ovf_flag: assert property (p_ovf_flag) else $error("flag lost to coincident clear");
   property p_cont_irq;
      (irq_overflow_status & ~$past(irq_overflow_status) & $past(continue_to_interrupt) & ~conversion_irq) == '0;
   endproperty
   a_cont_irq: assert property (p_cont_irq) else $error("continue line dropped an interrupt");
   property p_read;
      s_rd_req |=> s_rd_ans;
   endproperty
   a_read: assert property (p_read) else $error("read not answered");
endmodule // aif_sva
`default_nettype wire

// ---- bench/adc_interrupt_flag_logic_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module adc_interrupt_flag_logic_tb;
   // ****
   // Clock, stimulus and instances.
   // ****
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [3:0] conv_done = '0;
   logic [15:0] conv_data = '0;
   logic late = 1'b0;
   logic [3:0] div = '0;
   logic [3:0] cont = '0;
   logic res16 = 1'b0;
   logic diff = 1'b0;
   logic autoclr = 1'b1;
   logic [7:0] trim;
   logic [7:0] trim_exp [4] = '{aif_pkg::TRIM_12_SE, aif_pkg::TRIM_12_DIFF, aif_pkg::TRIM_16_SE, aif_pkg::TRIM_16_DIFF};
   logic stale;
   logic [15:0] res;
   logic [1:0] res_line;
   logic res_v;
   logic lost;
   int errors = 0;
   int comparisons = 0;
   int irq_n = 0;
   int lost_n = 0;
   int ln = 0;
   int n0;
   int l0;
   initial begin
      forever #(aif_pkg::CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
   end
   aif_link_if link ();
   aif_device aif_device_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .link(link.dev), .conv_done_i(conv_done),
      .conv_data_i(conv_data), .late_irq_mode_i(late), .clk_div_i(div), .offset_trim_o(trim), .stale_risk_o(stale));
   aif_host aif_host_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .link(link.host), .cont_cfg_i(cont),
      .res_16bit_cfg_i(res16), .diff_mode_cfg_i(diff), .ovf_autoclear_i(autoclr), .result_o(res),
      .result_line_o(res_line), .result_valid_o(res_v), .lost_o(lost));
   aif_sva #(.N(aif_pkg::NUM_LINES)) aif_sva_inst (.ref_clk_i(ref_clk), .rst_b_i(rst_b),
      .conversion_irq(link.conversion_irq), .conversion_irq_flag(link.conversion_irq_flag),
      .irq_overflow_status(link.irq_overflow_status), .irq_flag_clear(link.irq_flag_clear),
      .irq_overflow_clear(link.irq_overflow_clear), .continue_to_interrupt(link.continue_to_interrupt),
      .rd_req(link.rd_req), .rd_valid(link.rd_valid));
   always @(posedge ref_clk) begin
      irq_n <= irq_n + int'(link.conversion_irq[ln] === 1'b1);
      lost_n <= lost_n + int'(lost === 1'b1);
   end
   // ****
   // Tasks.
   // ****
   task tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task conv(input int l, input logic [15:0] d, input int n);
      conv_done[l] = 1'b1;
      for (int i = 0; i < n; i++) begin
         conv_data = d + 16'(i);
         tick(1);
      end
      conv_done = '0;
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task wfor(input int k);
      int i;
      for (i = 0; i < 60; i++) begin
         if (k == 0 ? res_v === 1'b1 : lost_n >= k) break;
         tick(1);
      end
      if (i == 60) begin
         errors++;
         stop_test();
      end
   endtask
   // ****
   // Tests.
   // ****
   initial begin
      tick(2);
      rst_b = 1'b1;
      tick(1);
      `CHK("trim", aif_pkg::TRIM_12_SE, trim)
      for (int m = 0; m < 4; m++) begin
         {res16, diff} = 2'(m);
         tick(3);
         `CHK("trim", trim_exp[m], trim)
      end
      {res16, diff} = 2'b00;
      late = 1'b1;
      div = 4'h3;
      tick(3);
      `CHK("stale", 1'b1, stale)
      div = 4'h2;
      tick(2);
      `CHK("stale", 1'b0, stale)
      late = 1'b0;
      div = 4'h3;
      tick(2);
      `CHK("stale", 1'b0, stale)
      $display("mode test done");
      ln = 1;
      n0 = irq_n;
      conv(1, 16'h1234, 1);
      wfor(0);
      `CHK("data", 16'h1234, res)
      `CHK("line", 2'h1, res_line)
      tick(4);
      `CHK("flag", 4'h0, link.conversion_irq_flag)
      `CHK("irqs", 1, irq_n - n0)
      $display("read test done");
      ln = 0;
      n0 = irq_n;
      l0 = lost_n;
      conv(0, 16'h0a0a, 2);
      wfor(l0 + 1);
      tick(3);
      `CHK("irqs", 1, irq_n - n0)
      `CHK("data", 16'h0a0b, res)
      `CHK("ovf", 4'h0, link.irq_overflow_status)
      `CHK("flag", 4'h0, link.conversion_irq_flag)
      $display("one-shot test done");
      ln = 2;
      cont = 4'hf;
      autoclr = 1'b0;
      tick(2);
      n0 = irq_n;
      l0 = lost_n;
      conv(2, 16'h0c00, 2);
      wfor(l0 + 1);
      tick(3);
      `CHK("irqs", 2, irq_n - n0)
      `CHK("ovf", 4'h4, link.irq_overflow_status)
      `CHK("flag", 4'h0, link.conversion_irq_flag)
      $display("continue test done");
      ln = 3;
      cont = 4'h0;
      autoclr = 1'b1;
      tick(2);
      n0 = irq_n;
      l0 = lost_n;
      conv(3, 16'h0d00, 1);
      wfor(0);
      `CHK("data", 16'h0d00, res)
      conv(3, 16'h0d01, 1);
      `CHK("flag", 4'h8, link.conversion_irq_flag)
      `CHK("ovf", 4'hc, link.irq_overflow_status)
      wfor(l0 + 1);
      tick(3);
      `CHK("irqs", 1, irq_n - n0)
      `CHK("flag", 4'h0, link.conversion_irq_flag)
      `CHK("ovf", 4'h4, link.irq_overflow_status)
      $display("coincidence test done");
      stop_test();
   end
endmodule // adc_interrupt_flag_logic_tb
`default_nettype wire
